// ==== verilog/airq_defines.vh ====
/*
  Constants for the accelerometer interrupt-status and data-configuration register slice:
  register offsets, field positions, reset values and range, oversampling and sample-rate codes.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef AIRQ_DEFINES_VH
`define AIRQ_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets on the register port
`define AIRQ_OFS_XMSB 8'h01
`define AIRQ_OFS_YMSB 8'h03
`define AIRQ_OFS_ZMSB 8'h05
`define AIRQ_OFS_IRQSRC 8'h0c
`define AIRQ_OFS_IDENT 8'h0d
`define AIRQ_OFS_RANGECFG 8'h0e
`define AIRQ_OFS_HPCFG 8'h0f
`define AIRQ_OFS_ORIENTSTAT 8'h10
`define AIRQ_OFS_FALLSRC 8'h16
`define AIRQ_OFS_TAPSRC 8'h22

////////////////////////////////////////////////////////////////////////////////
// Interrupt source bit positions
`define AIRQ_BIT_READY 0
`define AIRQ_BIT_FALL 2
`define AIRQ_BIT_TAP 3
`define AIRQ_BIT_ORIENT 4

////////////////////////////////////////////////////////////////////////////////
// Configuration fields
`define AIRQ_BIT_FILTOUT 4
`define AIRQ_BIT_TAPHPBYP 5
`define AIRQ_BIT_TAPLPEN 4
`define AIRQ_RANGECFG_MASK 8'h13
`define AIRQ_HPCFG_MASK 8'h33
`define AIRQ_RANGECFG_RST 8'h00
`define AIRQ_HPCFG_RST 8'h00
`define AIRQ_IDENT_DEFAULT 8'h5c // Arbitrary value

////////////////////////////////////////////////////////////////////////////////
// Range, oversampling and sample-rate codes
`define AIRQ_RANGE_2G 2'h0
`define AIRQ_RANGE_4G 2'h1
`define AIRQ_RANGE_8G 2'h2
`define AIRQ_OSM_NORMAL 2'h0
`define AIRQ_OSM_LOWNOISE 2'h1
`define AIRQ_OSM_HIGHRES 2'h2
`define AIRQ_OSM_LOWPOWER 2'h3
`define AIRQ_RATE_800 3'h0
`define AIRQ_RATE_12P5 3'h5

`endif

// ==== verilog/airq_hp_cutoff.v ====
/*
  High-pass cutoff lookup. Cutoff equals 16 Hz shifted right by cutoffShift.
  Assumes rate and oversampling codes are stable register values on ref_clk.
*/
`timescale 1ns/10ps
`include "airq_defines.vh"

module airq_hp_cutoff (
  // Selection
  input wire [1:0] cutoffSelect,
  input wire [2:0] rateCode,
  input wire [1:0] oversampleMode,
  // Result
  output reg [3:0] cutoffShift
);

  reg [3:0] rateShift;

  ////////////////////////////////////////////////////////////////////////////////
  // Rate index 0..7 is 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
  always @* begin
    rateShift = 4'h0;
    case (oversampleMode)
      `AIRQ_OSM_NORMAL: begin
        if (rateCode <= 3'h1)
          rateShift = 4'h0;
        else if (rateCode <= 3'h4)
          rateShift = {1'b0, rateCode} - 4'h1;
        else
          rateShift = 4'h3;
      end
      `AIRQ_OSM_LOWNOISE: begin
        if (rateCode <= 3'h1)
          rateShift = 4'h0;
        else if (rateCode < `AIRQ_RATE_12P5)
          rateShift = {1'b0, rateCode} - 4'h1;
        else
          rateShift = 4'h5; // RQ16
      end
      `AIRQ_OSM_HIGHRES: begin
        rateShift = 4'h0;
      end
      default: begin
        if (rateCode < `AIRQ_RATE_12P5)
          rateShift = {1'b0, rateCode};
        else
          rateShift = 4'h6;
      end
    endcase
    cutoffShift = rateShift + {2'b00, cutoffSelect}; // RQ15
  end

endmodule

// ==== verilog/airq_reg_bank.v ====
/*
  Interrupt-source, identity and data-configuration register slice of the accelerometer.
  Assumes a same-clock register port decoded from the serial interface, one-cycle read and
  write strobes, and event flags and enables from neighbouring logic on ref_clk.
*/
`timescale 1ns/10ps
`include "airq_defines.vh"

// Behaviour
// RQ1: Orientation source bit sets when orientation change occurs while its interrupt is enabled.
// RQ2: Reading the orientation status register clears the orientation source bit.
// RQ3: Tap source bit sets on tap event-active, single or double, when enabled.
// RQ4: Reading the tap source register clears the tap source bit.
// RQ5: Fall/motion source bit sets on its event-active flag when enabled.
// RQ6: Reading the fall/motion source register clears the fall/motion source bit.
// RQ7: Sample-ready source bit sets on new sample or overrun when enabled.
// RQ8: Sample-ready source bit clears only after X, Y and Z data reads.
// RQ9: Read-only eight-bit identity register returns the part identity code.
// RQ10: Filtered output select routes high-pass samples to data registers and FIFO.
// RQ11: Two-bit range field selects 2 g, 4 g, 8 g; 11 reserved.
// RQ12: Reset leaves 2 g range and unfiltered output data.
// RQ13: Tap high-pass bypass bit: 0 keeps filter, default; 1 bypasses it.
// RQ14: Tap low-pass enable bit: 1 inserts filter, 0 default leaves it out.
// RQ15: Cutoff follows select, rate and oversampling; normal 800 Hz gives 16..2 Hz.
// RQ16: Low-noise mode at 12.5 Hz and below gives 0.5 down to 0.063 Hz.
// RQ17: Source bits set on a rising edge of their event condition only.
// RQ18: Reading the source register changes no bit; bit 1 reads as zero.
module airq_reg_bank #(
  parameter [7:0] IDENTITY_CODE = `AIRQ_IDENT_DEFAULT // Arbitrary value
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Register port
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire [7:0] regWriteData,
  input wire regRead,
  output reg [7:0] regReadData,
  output reg regReadValid,
  output reg regReadHit,
  // Event flags
  input wire orientation_change_flag,
  input wire tapEventActive,
  input wire fallMotionEventActive,
  input wire xyz_new_sample_flag,
  input wire xyz_overrun_flag,
  // Interrupt enables
  input wire orientIrqEnable,
  input wire tapIrqEnable,
  input wire fallMotionIrqEnable,
  input wire sampleReadyIrqEnable,
  // Sample path
  input wire [11:0] sampleRaw,
  input wire [11:0] sampleHighpass,
  input wire sampleStrobe,
  output reg [11:0] sampleOut,
  output reg sampleOutValid,
  // Configuration outputs
  output wire [1:0] range_select,
  output wire filtered_output_select,
  output wire tap_highpass_bypass,
  output wire tap_lowpass_enable,
  // Cutoff derivation
  input wire [2:0] rateCode,
  input wire [1:0] oversampleMode,
  output reg [3:0] cutoffShift,
  // Source bits
  output wire orientation_irq_flag,
  output wire tap_irq_flag,
  output wire fall_motion_irq_flag,
  output wire sample_ready_irq_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [7:0] output_range_filter_config;
  reg [7:0] highpass_cutoff_pulse_filter;
  reg [3:0] condPrev;
  reg [3:0] srcFlag;
  reg [2:0] axisRead;
  reg [2:0] next_axisRead;
  reg [7:0] next_readData;
  reg next_readHit;
  wire [3:0] cond;
  wire [3:0] rise;
  wire [3:0] clearReq;
  wire readX;
  wire readY;
  wire readZ;
  wire axesDone;
  wire [3:0] cutoffShiftComb;
  wire [7:0] interrupt_source_status;

  ////////////////////////////////////////////////////////////////////////////////
  // Event conditions; index 0 ready, 1 fall/motion, 2 tap, 3 orientation
  assign cond[0] = (xyz_new_sample_flag | xyz_overrun_flag) & sampleReadyIrqEnable; // RQ7
  assign cond[1] = fallMotionEventActive & fallMotionIrqEnable; // RQ5
  assign cond[2] = tapEventActive & tapIrqEnable; // RQ3
  assign cond[3] = orientation_change_flag & orientIrqEnable; // RQ1
  assign rise = cond & ~condPrev; // RQ17

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      condPrev <= 4'h0;
    end else begin
      condPrev <= cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clearing reads
  assign readX = regRead && (regAddr == `AIRQ_OFS_XMSB);
  assign readY = regRead && (regAddr == `AIRQ_OFS_YMSB);
  assign readZ = regRead && (regAddr == `AIRQ_OFS_ZMSB);

  // A new sample restarts the axis tally so stale reads cannot clear it
  always @* begin
    next_axisRead = axisRead | {readZ, readY, readX};
    if (rise[0] || axesDone)
      next_axisRead = 3'h0;
  end

  assign axesDone = &(axisRead | {readZ, readY, readX}); // RQ8

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      axisRead <= 3'h0;
    end else begin
      axisRead <= next_axisRead;
    end
  end

  assign clearReq[0] = axesDone; // RQ8
  assign clearReq[1] = regRead && (regAddr == `AIRQ_OFS_FALLSRC); // RQ6
  assign clearReq[2] = regRead && (regAddr == `AIRQ_OFS_TAPSRC); // RQ4
  assign clearReq[3] = regRead && (regAddr == `AIRQ_OFS_ORIENTSTAT); // RQ2

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky source bits; a rising edge wins over a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gSource
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          srcFlag[gi] <= 1'b0;
        end else if (rise[gi]) begin
          srcFlag[gi] <= 1'b1; // RQ17
        end else if (clearReq[gi]) begin
          srcFlag[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign sample_ready_irq_flag = srcFlag[0];
  assign fall_motion_irq_flag = srcFlag[1];
  assign tap_irq_flag = srcFlag[2];
  assign orientation_irq_flag = srcFlag[3];

  // Upper source bits live elsewhere; bit 1 is driven low
  assign interrupt_source_status = {3'b000, srcFlag[3], srcFlag[2], srcFlag[1],
    1'b0, srcFlag[0]}; // RQ18

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers; reserved bits are masked off on write
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      output_range_filter_config <= `AIRQ_RANGECFG_RST; // RQ12
      highpass_cutoff_pulse_filter <= `AIRQ_HPCFG_RST; // RQ13 RQ14
    end else if (regWrite) begin
      if (regAddr == `AIRQ_OFS_RANGECFG)
        output_range_filter_config <= regWriteData & `AIRQ_RANGECFG_MASK;
      if (regAddr == `AIRQ_OFS_HPCFG)
        highpass_cutoff_pulse_filter <= regWriteData & `AIRQ_HPCFG_MASK;
    end
  end

  // Reserved code 11 is stored and passed on; the range logic decides its meaning
  assign range_select = output_range_filter_config[1:0]; // RQ11
  assign filtered_output_select = output_range_filter_config[`AIRQ_BIT_FILTOUT];
  assign tap_highpass_bypass = highpass_cutoff_pulse_filter[`AIRQ_BIT_TAPHPBYP]; // RQ13
  assign tap_lowpass_enable = highpass_cutoff_pulse_filter[`AIRQ_BIT_TAPLPEN]; // RQ14

  ////////////////////////////////////////////////////////////////////////////////
  // Sample source for data registers and FIFO alike
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sampleOut <= 12'h000;
      sampleOutValid <= 1'b0;
    end else begin
      sampleOutValid <= sampleStrobe;
      if (sampleStrobe)
        sampleOut <= filtered_output_select ? sampleHighpass : sampleRaw; // RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // High-pass cutoff
  airq_hp_cutoff uCutoff (
    .cutoffSelect(highpass_cutoff_pulse_filter[1:0]),
    .rateCode(rateCode),
    .oversampleMode(oversampleMode),
    .cutoffShift(cutoffShiftComb)
  );

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cutoffShift <= 4'h0;
    end else begin
      cutoffShift <= cutoffShiftComb; // RQ15 RQ16
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data; other offsets are answered by neighbouring banks
  always @* begin
    next_readData = 8'h00;
    next_readHit = 1'b1;
    case (regAddr)
      `AIRQ_OFS_IRQSRC: begin
        next_readData = interrupt_source_status; // RQ18
      end
      `AIRQ_OFS_IDENT: begin
        next_readData = IDENTITY_CODE; // RQ9
      end
      `AIRQ_OFS_RANGECFG: begin
        next_readData = output_range_filter_config;
      end
      `AIRQ_OFS_HPCFG: begin
        next_readData = highpass_cutoff_pulse_filter;
      end
      default: begin
        next_readHit = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regReadData <= 8'h00;
      regReadValid <= 1'b0;
      regReadHit <= 1'b0;
    end else begin
      regReadValid <= regRead;
      regReadHit <= regRead & next_readHit;
      if (regRead)
        regReadData <= next_readData;
    end
  end

endmodule

// ==== tb/airq_host_model.sv ====
/* Host model on the register port: byte reads and writes.
   Assumes the bench calls its tasks; changes land at falling edges. */
`timescale 1ns/10ps
module airq_host_model (
  // Port
  input wire ref_clk,
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWriteData,
  output logic regRead,
  input wire [7:0] regReadData,
  input wire regReadValid,
  input wire regReadHit
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWriteData = 8'h00;
    regRead = 1'b0;
  end
  // Released lines show the inverse, so a stale value never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    regAddr = a;
    regWriteData = v;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWriteData = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic h);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge ref_clk);
    // Answer stands one cycle only, so take it before release
    v = regReadValid ? regReadData : 8'hxx;
    h = regReadHit;
    regRead = 1'b0;
    regAddr = ~a;
  endtask
endmodule

// ==== tb/airq_reg_bank_props.sv ====
/* Checker for the register slice: source bits, identity, samples.
   Assumes binding to airq_reg_bank; one clock domain. */
`timescale 1ns/10ps
module airq_reg_bank_props #(
  parameter [7:0] IDENTITY_CODE = 8'h5c
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Register port
  input wire regRead,
  input wire regReadValid,
  input wire regReadHit,
  input wire [7:0] regAddr,
  input wire [7:0] regReadData,
  // Events and enables
  input wire orientation_change_flag,
  input wire tapEventActive,
  input wire fallMotionEventActive,
  input wire xyz_new_sample_flag,
  input wire xyz_overrun_flag,
  input wire orientIrqEnable,
  input wire tapIrqEnable,
  input wire fallMotionIrqEnable,
  input wire sampleReadyIrqEnable,
  // Sample path
  input wire sampleStrobe,
  input wire sampleOutValid,
  input wire filtered_output_select,
  input wire [11:0] sampleRaw,
  input wire [11:0] sampleHighpass,
  input wire [11:0] sampleOut,
  // Flags
  input wire orientation_irq_flag,
  input wire tap_irq_flag,
  input wire fall_motion_irq_flag,
  input wire sample_ready_irq_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire orC = orientation_change_flag && orientIrqEnable;
  wire tapC = tapEventActive && tapIrqEnable;
  wire fallC = fallMotionEventActive && fallMotionIrqEnable;
  wire rdyC = (xyz_new_sample_flag || xyz_overrun_flag) && sampleReadyIrqEnable;
  wire dataRd = regRead && (regAddr == 8'h01 || regAddr == 8'h03 || regAddr == 8'h05);
  a_orient_set: assert property ($rose(orC) |=> orientation_irq_flag)
    else $error("orient flag not set");
  a_orient_clr: assert property (regRead && regAddr == 8'h10 && !$rose(orC)
    |=> !orientation_irq_flag) else $error("orient flag not cleared");
  a_tap_set: assert property ($rose(tapC) |=> tap_irq_flag)
    else $error("tap flag not set");
  a_tap_clr: assert property (regRead && regAddr == 8'h22 && !$rose(tapC)
    |=> !tap_irq_flag) else $error("tap flag not cleared");
  a_fall_set: assert property ($rose(fallC) |=> fall_motion_irq_flag)
    else $error("fall flag not set");
  a_fall_clr: assert property (regRead && regAddr == 8'h16 && !$rose(fallC)
    |=> !fall_motion_irq_flag) else $error("fall flag not cleared");
  a_ready_set: assert property ($rose(rdyC) |=> sample_ready_irq_flag)
    else $error("ready flag not set");
  a_ready_hold: assert property (sample_ready_irq_flag && !dataRd |=> sample_ready_irq_flag)
    else $error("ready flag lost");
  a_ident_read: assert property (regRead && regAddr == 8'h0d
    |=> regReadValid && regReadHit && regReadData == IDENTITY_CODE) else $error("identity");
  a_sample_sel: assert property (sampleStrobe |=> sampleOutValid && sampleOut ==
    ($past(filtered_output_select) ? $past(sampleHighpass) : $past(sampleRaw)))
    else $error("sample select");
  a_tap_edge: assert property ($rose(tap_irq_flag) |-> $past(tapC) && !$past(tapC, 2))
    else $error("tap flag without edge");
  a_src_keep: assert property (regRead && regAddr == 8'h0c && tap_irq_flag |=> tap_irq_flag)
    else $error("source read cleared");
  cover property ($rose(tap_irq_flag));
  cover property (regRead && regAddr == 8'h0c);
  cover property (sampleOutValid && filtered_output_select);
endmodule
bind airq_reg_bank airq_reg_bank_props #(.IDENTITY_CODE(IDENTITY_CODE)) i_props (.*);

// ==== tb/test_accel_irq_status_data_config.sv ====
/* Bench for the register slice: port, source bits, samples, cutoff.
   Assumes the host model drives the port; events change at falling edges. */
`timescale 1ns/10ps
module test_accel_irq_status_data_config;
  localparam logic [7:0] ID = 8'ha5; // Arbitrary value
  localparam logic [7:0] SRC [3] = '{8'h10, 8'h22, 8'h16};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [3:0] en = 4'hf;
  logic nsf = 1'b0, ovf = 1'b0, strobe = 1'b0;
  logic [11:0] raw = 12'h123, hp = 12'habc;
  logic [2:0] rate = 3'h0;
  logic [1:0] osm = 2'h0;
  wire [7:0] regAddr, regWriteData, regReadData;
  wire regWrite, regRead, regReadValid, regReadHit, sov, fos, thb, tle;
  wire [11:0] sampleOut;
  wire [1:0] rng;
  wire [3:0] cs, fl;
  int bad_count = 0, check_count = 0;
  logic [7:0] d, w;
  logic h;
  always #5 ref_clk = ~ref_clk;
  airq_host_model i_host (.ref_clk, .regAddr, .regWrite, .regWriteData, .regRead,
    .regReadData, .regReadValid, .regReadHit);
  airq_reg_bank #(.IDENTITY_CODE(ID)) i_dut (.ref_clk, .resetn, .regAddr, .regWrite,
    .regWriteData, .regRead, .regReadData, .regReadValid, .regReadHit,
    .orientation_change_flag(ev[0]), .tapEventActive(ev[1]), .fallMotionEventActive(ev[2]),
    .xyz_new_sample_flag(nsf), .xyz_overrun_flag(ovf), .orientIrqEnable(en[0]),
    .tapIrqEnable(en[1]), .fallMotionIrqEnable(en[2]), .sampleReadyIrqEnable(en[3]),
    .sampleRaw(raw), .sampleHighpass(hp), .sampleStrobe(strobe), .sampleOut,
    .sampleOutValid(sov), .range_select(rng), .filtered_output_select(fos),
    .tap_highpass_bypass(thb), .tap_lowpass_enable(tle), .rateCode(rate),
    .oversampleMode(osm), .cutoffShift(cs), .orientation_irq_flag(fl[0]),
    .tap_irq_flag(fl[1]), .fall_motion_irq_flag(fl[2]), .sample_ready_irq_flag(fl[3]));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [8:0] e);
    i_host.rd(a, d, h);
    chk($sformatf("register %h", a), {7'h0, e}, {7'h0, h, d});
  endtask
  task automatic final_report();
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    $display("Error watchdog expected end seen timeout");
    final_report();
  end
  initial begin
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    rdchk(8'h0e, 9'h100);
    rdchk(8'h0f, 9'h100);
    i_host.wr(8'h0d, ~ID);
    rdchk(8'h0d, {1'b1, ID});
    rdchk(8'h7f, 9'h000);
    for (int r = 0; r < 4; r++) begin
      w = {3'h7, r[0], 2'h3, r[1:0]};
      i_host.wr(8'h0e, w);
      rdchk(8'h0e, {1'b1, w & 8'h13});
      strobe = 1'b1;
      @(negedge ref_clk);
      strobe = 1'b0;
      chk("sample", {1'b1, r[0] ? hp : raw}, {sov, sampleOut});
      chk("range", {r[0], r[1:0]}, {fos, rng});
    end
    for (int s = 0; s < 4; s++) begin
      w = {2'h3, s[1:0], 2'h3, s[1:0]};
      osm = 2'h0;
      rate = 3'h0;
      i_host.wr(8'h0f, w);
      rdchk(8'h0f, {1'b1, w & 8'h33});
      chk("tap filter", 16'(s), {thb, tle});
      chk("cutoff", 16'(s), cs);
      osm = 2'h1;
      rate = 3'h5;
      repeat (2) @(negedge ref_clk);
      chk("cutoff", 16'(s + 5), cs);
      osm = 2'h2;
      repeat (2) @(negedge ref_clk);
      chk("cutoff", 16'(s), cs);
      osm = 2'h3;
      rate = 3'h7;
      repeat (2) @(negedge ref_clk);
      chk("cutoff", 16'(s + 6), cs);
    end
    for (int i = 0; i < 3; i++) begin
      en[i] = 1'b0;
      ev[i] = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("masked", 0, fl[i]);
      ev[i] = 1'b0;
      en[i] = 1'b1;
      @(negedge ref_clk);
      ev[i] = 1'b1;
      @(negedge ref_clk);
      chk("raised", 1, fl[i]);
      i_host.rd(8'h0c, d, h);
      chk("source", 16'h1 << (4 - i), d & 8'hfd);
      chk("kept", 1, fl[i]);
      i_host.rd(SRC[i], d, h);
      chk("cleared", 0, fl[i]);
      repeat (3) @(negedge ref_clk);
      chk("held", 0, fl[i]);
      ev[i] = 1'b0;
    end
    en[3] = 1'b0;
    nsf = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("masked", 0, fl[3]);
    nsf = 1'b0;
    en[3] = 1'b1;
    @(negedge ref_clk);
    nsf = 1'b1;
    @(negedge ref_clk);
    chk("ready", 1, fl[3]);
    i_host.rd(8'h01, d, h);
    i_host.rd(8'h05, d, h);
    chk("ready", 1, fl[3]);
    i_host.rd(8'h03, d, h);
    chk("ready", 0, fl[3]);
    nsf = 1'b0;
    @(negedge ref_clk);
    ovf = 1'b1;
    @(negedge ref_clk);
    chk("overrun", 1, fl[3]);
    ovf = 1'b0;
    resetn = 1'b0;
    @(negedge ref_clk);
    resetn = 1'b1;
    rdchk(8'h0e, 9'h100);
    rdchk(8'h0f, 9'h100);
    final_report();
  end
endmodule
